// ---- alarm_pkg.sv ----
// Register map, field layout, reset values and codes of the alarm monitor
package alarm_pkg;
    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [5:0] CTRL_OFS = 6'h00;
    localparam logic [5:0] ACK_OFS = 6'h04;
    localparam logic [5:0] OV_LIM_OFS = 6'h08;
    localparam logic [5:0] OC_LIM_OFS = 6'h0c;
    localparam logic [5:0] OP_LIM_OFS = 6'h10;
    localparam logic [5:0] EV_TH_OFS = 6'h14;
    localparam logic [5:0] EV_ACT_OFS = 6'h28;
    localparam logic [5:0] STAT_OFS = 6'h2c;
    localparam logic [5:0] IRQ_STAT_OFS = 6'h30;
    localparam logic [5:0] IRQ_CLR_OFS = 6'h34;
    localparam logic [5:0] IRQ_EN_OFS = 6'h38;
    // ----------------------------------------
    // Fields and indices
    // ----------------------------------------
    localparam int CTRL_SOUND_BIT = 0;
    localparam int CTRL_LINK_EN_BIT = 1;
    localparam int NA = 6;
    localparam int NE = 5;
    localparam int NS = 11;
    localparam int A_OV = 0;
    localparam int A_OC = 1;
    localparam int A_OP = 2;
    localparam int A_HOT = 3;
    localparam int A_SUPPLY = 4;
    localparam int A_LINK = 5;
    localparam int E_UV = 0;
    localparam int E_OV = 1;
    localparam int E_UC = 2;
    localparam int E_OC = 3;
    localparam int E_OP = 4;
    // ----------------------------------------
    // Nominal values and threshold limits
    // ----------------------------------------
    localparam logic [31:0] NOM_U = 32'h4000;
    localparam logic [31:0] NOM_I = 32'h4000;
    localparam logic [31:0] NOM_P = 32'h4000;
    localparam logic [31:0] PCT_OV_LIM = 32'h67;
    localparam logic [31:0] PCT_OC_LIM = 32'h6e;
    localparam logic [31:0] PCT_FULL = 32'h64;
    localparam logic [15:0] OV_LIM_MAX = 16'((NOM_U * PCT_OV_LIM) / PCT_FULL);
    localparam logic [15:0] OC_LIM_MAX = 16'((NOM_I * PCT_OC_LIM) / PCT_FULL);
    localparam logic [15:0] OP_LIM_MAX = 16'((NOM_P * PCT_OC_LIM) / PCT_FULL);
    localparam logic [15:0] EV_U_MAX = 16'(NOM_U);
    localparam logic [15:0] EV_I_MAX = 16'(NOM_I);
    localparam logic [15:0] EV_P_MAX = 16'(NOM_P);
    // ----------------------------------------
    // Reset values and codes
    // ----------------------------------------
    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam logic [9:0] EV_ACT_RST = 10'h000;
    localparam logic [15:0] EV_TH_RST = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ACT_NONE = 2'b00,
        ACT_SIGNAL = 2'b01,
        ACT_WARNING = 2'b10,
        ACT_ALARM = 2'b11
    } action_e;
endpackage

// ---- protection_alarm_monitor.sv ----
// Protection alarm and user event supervisor with AXI4-Lite registers
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module protection_alarm_monitor (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] meas_voltage,
    input wire logic [15:0] meas_current,
    input wire logic [15:0] meas_power,
    input wire logic meas_strobe,
    input wire logic dc_input_on,
    input wire logic overtemp_pin,
    input wire logic supply_fail_pin,
    input wire logic link_lost_pin,
    input wire logic link_init_pin,
    output logic dc_off_req,
    output logic alarm_popup,
    output logic warning_popup,
    output logic sound_out,
    output logic [alarm_pkg::NE-1:0] event_status_ind,
    output logic [alarm_pkg::NA-1:0] alarm_ind,
    output logic analog_alarm,
    output logic irq
);
    import alarm_pkg::*;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [3:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_r;
    logic link_init_d_r;
    logic overtemp, supply_fail, link_lost, link_init;

    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
            pin_s3_r <= 4'h0;
            pin_r <= 4'h0;
            link_init_d_r <= 1'b0;
        end else begin
            pin_s1_r <= {link_init_pin, link_lost_pin, supply_fail_pin, overtemp_pin};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_r <= (pin_s2_r == pin_s3_r) ? pin_s2_r : pin_r;
            link_init_d_r <= pin_r[3];
        end
    end
    assign overtemp = pin_r[0];
    assign supply_fail = pin_r[1];
    assign link_lost = pin_r[2];
    assign link_init = pin_r[3];

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    logic [1:0] ctrl_r;
    logic [15:0] ov_lim_r, oc_lim_r, op_lim_r;
    logic [15:0] ev_th_r [NE];
    logic [9:0] ev_act_r;
    logic [NS-1:0] latch_r, cond, irq_st_r, irq_en_r;
    logic wr_go, rd_go;
    logic [NS-1:0] ack_w, irq_clr_w;
    logic [31:0] rd_val;
    logic rd_ok;

    // Write address and data are taken together, one write at a time
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready <= wr_go;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (s_axi_awaddr <= IRQ_EN_OFS && s_axi_awaddr[1:0] == 2'b00
                    && s_axi_awaddr != STAT_OFS && s_axi_awaddr != IRQ_STAT_OFS)
                    ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lim);
        clamp = (v > lim) ? lim : v;
    endfunction

    // Configuration registers; thresholds clamp to their range
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= CTRL_RST;
            ov_lim_r <= OV_LIM_MAX;
            oc_lim_r <= OC_LIM_MAX;
            op_lim_r <= OP_LIM_MAX;
            ev_act_r <= EV_ACT_RST;
            irq_en_r <= '0;
            for (int k = 0; k < NE; k++) begin
                ev_th_r[k] <= EV_TH_RST;
            end
        end else if (wr_go && s_axi_wstrb[0]) begin
            unique case (s_axi_awaddr)
                CTRL_OFS: ctrl_r <= s_axi_wdata[1:0];
                OV_LIM_OFS: ov_lim_r <= clamp(s_axi_wdata[15:0], OV_LIM_MAX);
                OC_LIM_OFS: oc_lim_r <= clamp(s_axi_wdata[15:0], OC_LIM_MAX);
                OP_LIM_OFS: op_lim_r <= clamp(s_axi_wdata[15:0], OP_LIM_MAX);
                EV_TH_OFS: ev_th_r[E_UV] <= clamp(s_axi_wdata[15:0], EV_U_MAX);
                EV_TH_OFS + 6'h04: ev_th_r[E_OV] <= clamp(s_axi_wdata[15:0], EV_U_MAX);
                EV_TH_OFS + 6'h08: ev_th_r[E_UC] <= clamp(s_axi_wdata[15:0], EV_I_MAX);
                EV_TH_OFS + 6'h0c: ev_th_r[E_OC] <= clamp(s_axi_wdata[15:0], EV_I_MAX);
                EV_TH_OFS + 6'h10: ev_th_r[E_OP] <= clamp(s_axi_wdata[15:0], EV_P_MAX);
                EV_ACT_OFS: ev_act_r <= s_axi_wdata[9:0];
                IRQ_EN_OFS: irq_en_r <= s_axi_wdata[NS-1:0];
                default: ;
            endcase
        end
    end

    // Acknowledge and interrupt clear are write-one pulses
    assign ack_w = (wr_go && s_axi_awaddr == ACK_OFS) ? s_axi_wdata[NS-1:0] : '0;
    assign irq_clr_w = (wr_go && s_axi_awaddr == IRQ_CLR_OFS) ? s_axi_wdata[NS-1:0] : '0;

    // Read mux; write-only registers read as zero
    always_comb begin
        rd_val = 32'h0;
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            CTRL_OFS: rd_val = {30'h0, ctrl_r};
            ACK_OFS: rd_val = 32'h0;
            OV_LIM_OFS: rd_val = {16'h0, ov_lim_r};
            OC_LIM_OFS: rd_val = {16'h0, oc_lim_r};
            OP_LIM_OFS: rd_val = {16'h0, op_lim_r};
            EV_TH_OFS: rd_val = {16'h0, ev_th_r[E_UV]};
            EV_TH_OFS + 6'h04: rd_val = {16'h0, ev_th_r[E_OV]};
            EV_TH_OFS + 6'h08: rd_val = {16'h0, ev_th_r[E_UC]};
            EV_TH_OFS + 6'h0c: rd_val = {16'h0, ev_th_r[E_OC]};
            EV_TH_OFS + 6'h10: rd_val = {16'h0, ev_th_r[E_OP]};
            EV_ACT_OFS: rd_val = {22'h0, ev_act_r};
            STAT_OFS: rd_val = {10'h0, cond, latch_r};
            IRQ_STAT_OFS: rd_val = {21'h0, irq_st_r};
            IRQ_CLR_OFS: rd_val = 32'h0;
            IRQ_EN_OFS: rd_val = {21'h0, irq_en_r};
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Condition evaluation
    // ----------------------------------------
    logic [2:0] prot_cond_r;
    logic [NE-1:0] ev_cond_r, ev_hit;
    logic link_cond, link_clear;

    // Event comparisons against their own thresholds
    assign ev_hit[E_UV] = meas_voltage < ev_th_r[E_UV];
    assign ev_hit[E_OV] = meas_voltage > ev_th_r[E_OV];
    assign ev_hit[E_UC] = meas_current < ev_th_r[E_UC];
    assign ev_hit[E_OC] = meas_current > ev_th_r[E_OC];
    assign ev_hit[E_OP] = meas_power > ev_th_r[E_OP];

    // Conditions refresh on each measurement sample
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prot_cond_r <= 3'h0;
            ev_cond_r <= '0;
        end else begin
            if (meas_strobe) begin
                prot_cond_r[A_OV] <= meas_voltage >= ov_lim_r;
                prot_cond_r[A_OC] <= meas_current >= oc_lim_r;
                prot_cond_r[A_OP] <= meas_power >= op_lim_r;
            end
            if (!dc_input_on) begin
                ev_cond_r <= '0;
            end else if (meas_strobe) begin
                ev_cond_r <= ev_hit;
            end
        end
    end

    // Link alarm: lost slave or uninitialized while enabled
    assign link_cond = ctrl_r[CTRL_LINK_EN_BIT] && (link_lost || !link_init);
    assign link_clear = !ctrl_r[CTRL_LINK_EN_BIT] || (link_init && !link_init_d_r);
    assign cond = {ev_cond_r, link_cond, supply_fail, overtemp, prot_cond_r};

    // ----------------------------------------
    // Sticky latches
    // ----------------------------------------
    logic [NS-1:0] set_v, clr_v;
    genvar g;
    generate
        for (g = 0; g < NS; g++) begin : g_latch
            if (g >= NA) begin : g_ev
                // Event with no action never latches
                assign set_v[g] = cond[g]
                    && action_e'(ev_act_r[2*(g-NA) +: 2]) != ACT_NONE;
                assign clr_v[g] = (ack_w[g] && !cond[g])
                    || action_e'(ev_act_r[2*(g-NA) +: 2]) == ACT_NONE;
            end else if (g == A_LINK) begin : g_link
                assign set_v[g] = cond[g];
                assign clr_v[g] = link_clear;
            end else begin : g_dev
                assign set_v[g] = cond[g];
                assign clr_v[g] = ack_w[g] && !cond[g];
            end
            // Set wins over clear
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    latch_r[g] <= 1'b0;
                end else if (set_v[g]) begin
                    latch_r[g] <= 1'b1;
                end else if (clr_v[g]) begin
                    latch_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Indications and interrupt
    // ----------------------------------------
    logic [NE-1:0] ev_warn, ev_alarm;
    generate
        for (g = 0; g < NE; g++) begin : g_act
            assign ev_warn[g] = latch_r[NA+g]
                && action_e'(ev_act_r[2*g +: 2]) == ACT_WARNING;
            assign ev_alarm[g] = latch_r[NA+g]
                && action_e'(ev_act_r[2*g +: 2]) == ACT_ALARM;
        end
    endgenerate

    // Registered outputs derived from the latches
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dc_off_req <= 1'b0;
            alarm_popup <= 1'b0;
            warning_popup <= 1'b0;
            sound_out <= 1'b0;
            event_status_ind <= '0;
            alarm_ind <= '0;
            analog_alarm <= 1'b0;
        end else begin
            dc_off_req <= |latch_r[NA-1:0] || |ev_alarm;
            alarm_popup <= |latch_r[NA-1:0] || |ev_alarm;
            warning_popup <= |ev_warn;
            sound_out <= ctrl_r[CTRL_SOUND_BIT]
                && (|latch_r[NA-1:0] || |ev_alarm);
            event_status_ind <= latch_r[NS-1:NA];
            alarm_ind <= latch_r[NA-1:0];
            analog_alarm <= |latch_r[A_SUPPLY:A_OV];
        end
    end

    // Rising latches set sticky status; set wins over clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_st_r <= '0;
            irq <= 1'b0;
        end else begin
            irq_st_r <= (irq_st_r & ~irq_clr_w) | (set_v & ~latch_r);
            irq <= |(irq_st_r & irq_en_r);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_ack_gone(int i);
        ack_w[i] && !cond[i] && !set_v[i];
    endsequence

    chk_none_no_latch: assert property (
        action_e'(ev_act_r[1:0]) == ACT_NONE |=> !latch_r[NA])
        else $error("event with no action latched");
    chk_ov_fires_off: assert property (
        meas_strobe && meas_voltage >= ov_lim_r |=> ##1 latch_r[A_OV] ##1 dc_off_req)
        else $error("overvoltage did not request dc off");
    chk_alarm_sticky: assert property (
        latch_r[A_HOT] && !ack_w[A_HOT] |=> latch_r[A_HOT])
        else $error("alarm cleared without acknowledge");
    chk_ack_clears: assert property (
        s_ack_gone(A_OC) and latch_r[A_OC] |=> !latch_r[A_OC])
        else $error("acknowledged alarm not cleared");
    chk_ack_persist: assert property (
        ack_w[A_OP] && cond[A_OP] |=> latch_r[A_OP])
        else $error("persisting alarm cleared by acknowledge");
    chk_link_hold: assert property (
        latch_r[A_LINK] && !link_clear |=> latch_r[A_LINK])
        else $error("link alarm cleared early");
    chk_events_off: assert property (
        !dc_input_on |=> ev_cond_r == '0)
        else $error("event condition while dc input off");
    chk_sound_gate: assert property (
        sound_out |-> $past(ctrl_r[CTRL_SOUND_BIT]) && alarm_popup)
        else $error("sound without enable or alarm");
    chk_signal_quiet: assert property (
        latch_r[NS-1:NA] != '0 && (ev_warn | ev_alarm) == '0 && latch_r[NA-1:0] == '0
        |=> !alarm_popup && !warning_popup && !dc_off_req)
        else $error("signal action raised popup or dc off");
endmodule
`default_nettype wire

// ---- meas_front_model.sv ----
// Measurement front end model feeding samples to the alarm monitor
`timescale 1ns/1ps
`default_nettype none
module meas_front_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] v_set,
    input wire logic [15:0] i_set,
    input wire logic [15:0] p_set,
    output logic [15:0] meas_voltage,
    output logic [15:0] meas_current,
    output logic [15:0] meas_power,
    output logic meas_strobe
);
    logic [2:0] tick_r;
    // One sample every eight cycles; between samples the buses carry junk
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tick_r <= 3'h0;
            meas_strobe <= 1'b0;
            meas_voltage <= 16'h0000;
            meas_current <= 16'h0000;
            meas_power <= 16'h0000;
        end else begin
            tick_r <= tick_r + 3'h1;
            meas_strobe <= (tick_r == 3'h7);
            meas_voltage <= (tick_r == 3'h7) ? v_set : ~v_set;
            meas_current <= (tick_r == 3'h7) ? i_set : ~i_set;
            meas_power <= (tick_r == 3'h7) ? p_set : ~p_set;
        end
    end
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the protection alarm monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
    import alarm_pkg::*;
    logic clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, ms, dc_on, hot, pfail, lost, init;
    logic dc_off, apop, wpop, snd, aalm, irq;
    logic [5:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_data;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rd_resp;
    logic [15:0] v_set, i_set, p_set, mv, mi, mp;
    logic [NE-1:0] evi;
    logic [NA-1:0] ali;
    int n_mismatch = 0;
    int comparisons = 0;
    // ----------------------------------------
    // Clock, reset, design and front end
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    protection_alarm_monitor u_dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .meas_voltage(mv), .meas_current(mi), .meas_power(mp),
        .meas_strobe(ms), .dc_input_on(dc_on), .overtemp_pin(hot), .supply_fail_pin(pfail),
        .link_lost_pin(lost), .link_init_pin(init), .dc_off_req(dc_off), .alarm_popup(apop),
        .warning_popup(wpop), .sound_out(snd), .event_status_ind(evi), .alarm_ind(ali),
        .analog_alarm(aalm), .irq(irq));
    meas_front_model u_front (.clk(clk), .resetn(resetn), .v_set(v_set), .i_set(i_set),
        .p_set(p_set), .meas_voltage(mv), .meas_current(mi), .meas_power(mp),
        .meas_strobe(ms));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Write: address and data offered together, each dropped once taken
    task automatic bus_wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("bvalid", 32'h1, 32'(bvalid));
        chk("bresp", 32'(er), 32'(bresp));
        // One idle edge, so a following request never re-raises a signal in this step
        @(posedge clk);
    endtask
    task automatic bus_rd(input logic [5:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd_data = rdata;
        rd_resp = rresp;
        rready <= 1'b0;
        chk("rvalid", 32'h1, 32'(rvalid));
        @(posedge clk);
    endtask
    task automatic rdc(input logic [5:0] a, input logic [31:0] e);
        bus_rd(a);
        chk("rdata", e, rd_data);
        chk("rresp", 32'(RESP_OKAY), 32'(rd_resp));
    endtask
    // Indication outputs; alarm popup always follows the DC-off request
    task automatic outs(input logic [31:0] ea, ee, edc, ew, es);
        chk("alarm_ind", ea, 32'(ali));
        chk("event_status_ind", ee, 32'(evi));
        chk("dc_off_req", edc, 32'(dc_off));
        chk("alarm_popup", edc, 32'(apop));
        chk("warning_popup", ew, 32'(wpop));
        chk("sound_out", es, 32'(snd));
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_defaults();
        rdc(OV_LIM_OFS, 32'(NOM_U * 103 / 100));
        rdc(OC_LIM_OFS, 32'(NOM_I * 110 / 100));
        rdc(OP_LIM_OFS, 32'(NOM_P * 110 / 100));
        rdc(CTRL_OFS, 32'h1);
        rdc(EV_ACT_OFS, 32'h0);
        bus_rd(6'h3c);
        chk("rresp", 32'(RESP_SLVERR), 32'(rd_resp));
        bus_wr(STAT_OFS, 32'h7ff, RESP_SLVERR);
        $display("test defaults done");
    endtask
    // Each protection alarm at threshold minus one, at threshold, acked early and late
    task automatic t_protect();
        logic [5:0] ofs [3];
        ofs = '{OV_LIM_OFS, OC_LIM_OFS, OP_LIM_OFS};
        for (int k = 0; k < 3; k++) begin
            bus_wr(IRQ_EN_OFS, (k == 1) ? 32'h0 : 32'h7ff, RESP_OKAY);
            bus_wr(ofs[k], 32'h1000, RESP_OKAY);
            v_set <= (k == 0) ? 16'h0fff : 16'h0000;
            i_set <= (k == 1) ? 16'h0fff : 16'h0000;
            p_set <= (k == 2) ? 16'h0fff : 16'h0000;
            step(20);
            outs(0, 0, 0, 0, 0);
            v_set <= (k == 0) ? 16'h1000 : 16'h0000;
            i_set <= (k == 1) ? 16'h1000 : 16'h0000;
            p_set <= (k == 2) ? 16'h1000 : 16'h0000;
            step(20);
            outs(32'h1 << k, 0, 1, 0, 1);
            chk("analog_alarm", 32'h1, 32'(aalm));
            chk("irq", 32'(k != 1), 32'(irq));
            rdc(IRQ_STAT_OFS, 32'h1 << k);
            bus_wr(ACK_OFS, 32'h1 << k, RESP_OKAY);
            step(20);
            chk("alarm_ind", 32'h1 << k, 32'(ali));
            v_set <= 16'h0000;
            i_set <= 16'h0000;
            p_set <= 16'h0000;
            step(20);
            chk("alarm_ind", 32'h1 << k, 32'(ali));
            bus_wr(ACK_OFS, 32'h1 << k, RESP_OKAY);
            step(20);
            outs(0, 0, 0, 0, 0);
            bus_wr(IRQ_CLR_OFS, 32'h7ff, RESP_OKAY);
            step(3);
            chk("irq", 32'h0, 32'(irq));
        end
        $display("test protect done");
    endtask
    task automatic t_hw();
        bus_wr(CTRL_OFS, 32'h0, RESP_OKAY);
        hot <= 1'b1;
        step(20);
        outs(32'h8, 0, 1, 0, 0);
        chk("analog_alarm", 32'h1, 32'(aalm));
        hot <= 1'b0;
        pfail <= 1'b1;
        step(20);
        bus_wr(ACK_OFS, 32'h8, RESP_OKAY);
        bus_wr(CTRL_OFS, 32'h1, RESP_OKAY);
        step(20);
        outs(32'h10, 0, 1, 0, 1);
        pfail <= 1'b0;
        step(20);
        bus_wr(ACK_OFS, 32'h10, RESP_OKAY);
        step(20);
        outs(0, 0, 0, 0, 0);
        $display("test hw_alarms done");
    endtask
    task automatic t_link();
        bus_wr(CTRL_OFS, 32'h3, RESP_OKAY);
        step(20);
        outs(0, 0, 0, 0, 0);
        lost <= 1'b1;
        step(20);
        outs(32'h20, 0, 1, 0, 1);
        chk("analog_alarm", 32'h0, 32'(aalm));
        lost <= 1'b0;
        bus_wr(ACK_OFS, 32'h20, RESP_OKAY);
        step(20);
        chk("alarm_ind", 32'h20, 32'(ali));
        init <= 1'b0;
        step(20);
        init <= 1'b1;
        step(20);
        outs(0, 0, 0, 0, 0);
        lost <= 1'b1;
        step(20);
        bus_wr(CTRL_OFS, 32'h1, RESP_OKAY);
        step(20);
        outs(0, 0, 0, 0, 0);
        lost <= 1'b0;
        $display("test link done");
    endtask
    // All five events, then every action code on the overvoltage event
    task automatic t_events();
        logic [31:0] th [5];
        th = '{32'he00, 32'ha00, 32'he00, 32'ha00, 32'ha00};
        dc_on <= 1'b1;
        for (int e = 0; e < 5; e++) begin
            bus_wr(EV_TH_OFS + 6'(4 * e), th[e], RESP_OKAY);
        end
        v_set <= 16'h0c00;
        i_set <= 16'h0c00;
        p_set <= 16'h0c00;
        bus_wr(EV_ACT_OFS, 32'h155, RESP_OKAY);
        step(20);
        outs(0, 32'h1f, 0, 0, 0);
        for (int a = 0; a < 4; a++) begin
            bus_wr(EV_ACT_OFS, 32'(a) << 2, RESP_OKAY);
            step(20);
            outs(0, 32'(a != 0) << 1, 32'(a == 3), 32'(a == 2), 32'(a == 3));
            bus_wr(EV_ACT_OFS, 32'h0, RESP_OKAY);
        end
        dc_on <= 1'b0;
        step(4);
        bus_wr(EV_ACT_OFS, 32'h3ff, RESP_OKAY);
        step(20);
        outs(0, 0, 0, 0, 0);
        $display("test events done");
    endtask
    // ----------------------------------------
    // Verdict, watchdog and main sequence
    // ----------------------------------------
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        resetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, dc_on, hot, pfail, lost} = '0;
        init = 1'b1;
        awaddr = 6'h00;
        araddr = 6'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        {v_set, i_set, p_set} = '0;
        step(12);
        resetn <= 1'b1;
        step(1);
        t_defaults();
        t_protect();
        t_hw();
        t_link();
        t_events();
        end_of_test();
    end
endmodule
`default_nettype wire
